// ---- rtl/hpb_device.sv ----
// Device end: host registers, data buffer and byte-wise serial engine
`timescale 1ns/1ps
`include "hpb_cfg.svh"
// Summary of operation
// - Write strobe and select low capture data
// - Write takes effect on strobe rising edge
// - Read strobe and select drive register
// - Read cycle starts at read falling edge
// - Select high releases all data lines
// - Transfers only while chip select low
// - Host sets register select before access
// - Interrupt output active low, open drain
// - Reset loads register defaults (status F8, timeout FF, others 00) and clears serial engine
// - Eight-bit bidirectional bus, bit0 least significant
// - Bytes move singly; interrupt or polling
// - Device makes all serial timing itself
// - Select codes: status/timeout, data, address, control
module hpb_device #(
	parameter int BYTE_CYC = `HPB_BYTE_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	hpb_if.device bus,
	input wire logic ser_in,
	output logic ser_out,
	output logic ser_clk,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	input wire logic rx_ready
);
	initial begin
		if (BYTE_CYC < 2 || BYTE_CYC > 255) $error("BYTE_CYC out of range");
	end
	typedef struct packed {
		logic [2:0] cs_s1, cs_s2;
		logic [2:0] wr_s1, wr_s2;
		logic [2:0] rd_s1, rd_s2;
		logic [1:0] sel_s1, sel_s2;
		logic [7:0] dat_s1, dat_s2;
		logic wr_prev;
		logic rd_prev;
		logic [1:0] wsel;
		logic [7:0] wdat;
		logic [7:0] status;
		logic [7:0] timeout;
		logic [7:0] data;
		logic [7:0] ownaddr;
		logic [7:0] control;
		logic [7:0] rdata;
		logic [7:0] buf0, buf1;
		logic [1:0] cnt;
		logic [7:0] shreg;
		logic [7:0] bitcnt;
		logic [3:0] bits;
		hpb_pkg::hpb_ser_state_type st;
		logic ser_out;
		logic ser_clk;
		logic irq;
	} hpb_dev_state_type;
	hpb_dev_state_type s_q, s_d;
	logic wr_rise, rd_fall, push;
	assign bus.dev_data_oe = ~s_q.cs_s2[0] & ~s_q.rd_s2[0] & ~bus.chip_select_n & ~bus.read_strobe_n;
	assign bus.host_data_from_dev = s_q.rdata;
	assign bus.irq_drive_low = s_q.irq;
	assign ser_out = s_q.ser_out;
	assign ser_clk = s_q.ser_clk;
	assign rx_byte = s_q.buf0;
	assign rx_valid = s_q.cnt != 2'h0;
	always_comb begin
		s_d = s_q;
		s_d.cs_s1 = {2'b00, bus.chip_select_n};
		s_d.cs_s2 = s_q.cs_s1;
		s_d.wr_s1 = {2'b00, bus.write_strobe_n};
		s_d.wr_s2 = s_q.wr_s1;
		s_d.rd_s1 = {2'b00, bus.read_strobe_n};
		s_d.rd_s2 = s_q.rd_s1;
		s_d.sel_s1 = {bus.register_select_msb, bus.register_select_lsb};
		s_d.sel_s2 = s_q.sel_s1;
		s_d.dat_s1 = bus.host_data_bus;
		s_d.dat_s2 = s_q.dat_s1;
		s_d.wr_prev = s_q.wr_s2[0];
		s_d.rd_prev = s_q.rd_s2[0];
		wr_rise = s_q.wr_s2[0] & ~s_q.wr_prev;
		rd_fall = ~s_q.rd_s2[0] & s_q.rd_prev;
		push = 1'b0;
		// Latch data while the strobe is low, commit on its rising edge
		if (~s_q.wr_s2[0] & ~s_q.cs_s2[0]) begin
			s_d.wsel = s_q.sel_s2;
			s_d.wdat = s_q.dat_s2;
		end
		if (wr_rise) begin
			case (s_q.wsel)
				`HPB_SEL_STATUS: s_d.timeout = s_q.wdat;
				`HPB_SEL_DATA: s_d.data = s_q.wdat;
				`HPB_SEL_OWNADDR: s_d.ownaddr = s_q.wdat;
				`HPB_SEL_CONTROL: s_d.control = s_q.wdat;
				default: s_d.data = s_q.wdat;
			endcase
		end
		if (rd_fall & ~s_q.cs_s2[0]) begin
			case (s_q.sel_s2)
				`HPB_SEL_STATUS: s_d.rdata = s_q.status;
				`HPB_SEL_DATA: s_d.rdata = s_q.data;
				`HPB_SEL_OWNADDR: s_d.rdata = s_q.ownaddr;
				`HPB_SEL_CONTROL: s_d.rdata = s_q.control;
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Serial engine, self-timed one byte at a time
		case (s_q.st)
			hpb_pkg::HPB_SER_IDLE: begin
				s_d.ser_clk = 1'b0;
				if (wr_rise && s_q.wsel == `HPB_SEL_CONTROL && s_q.wdat[`HPB_CTL_ENABLE_BIT]) begin
					s_d.shreg = s_q.data;
					s_d.bits = 4'h0;
					s_d.bitcnt = 8'h00;
					s_d.st = hpb_pkg::HPB_SER_SHIFT;
				end
			end
			hpb_pkg::HPB_SER_SHIFT: begin
				s_d.bitcnt = s_q.bitcnt + 8'h01;
				s_d.ser_out = s_q.shreg[7];
				if (s_q.bitcnt == 8'(BYTE_CYC - 1)) begin
					s_d.bitcnt = 8'h00;
					s_d.ser_clk = ~s_q.ser_clk;
					if (s_q.ser_clk) begin
						s_d.shreg = {s_q.shreg[6:0], ser_in};
						s_d.bits = s_q.bits + 4'h1;
						if (s_q.bits == 4'h7) s_d.st = hpb_pkg::HPB_SER_DONE;
					end
				end
			end
			hpb_pkg::HPB_SER_DONE: begin
				if (s_q.cnt != 2'h2) begin
					push = 1'b1;
					s_d.data = s_q.shreg;
					s_d.status = `HPB_STA_BYTE_DONE;
					s_d.control[`HPB_CTL_IRQ_BIT] = 1'b1;
					s_d.st = hpb_pkg::HPB_SER_WAIT;
				end
			end
			hpb_pkg::HPB_SER_WAIT: begin
				if (~s_q.control[`HPB_CTL_IRQ_BIT]) begin
					s_d.status = `HPB_STA_IDLE;
					s_d.st = hpb_pkg::HPB_SER_IDLE;
				end
			end
			default: s_d.st = hpb_pkg::HPB_SER_IDLE;
		endcase
		// Host clears the flag by writing control; a new byte's set wins
		if (wr_rise && s_q.wsel == `HPB_SEL_CONTROL && !push)
			s_d.control[`HPB_CTL_IRQ_BIT] = s_q.wdat[`HPB_CTL_IRQ_BIT];
		s_d.irq = s_d.control[`HPB_CTL_IRQ_BIT];
		// Two-entry buffer toward the user side
		if (rx_valid & rx_ready) begin
			s_d.buf0 = s_q.buf1;
			s_d.cnt = s_q.cnt - 2'h1;
			if (push) begin
				if (s_q.cnt == 2'h1) s_d.buf0 = s_q.shreg;
				else s_d.buf1 = s_q.shreg;
				s_d.cnt = s_q.cnt;
			end
		end else if (push) begin
			if (s_q.cnt == 2'h0) s_d.buf0 = s_q.shreg;
			else s_d.buf1 = s_q.shreg;
			s_d.cnt = s_q.cnt + 2'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.cs_s1 <= 3'h1;
			s_q.cs_s2 <= 3'h1;
			s_q.wr_s1 <= 3'h1;
			s_q.wr_s2 <= 3'h1;
			s_q.rd_s1 <= 3'h1;
			s_q.rd_s2 <= 3'h1;
			s_q.wr_prev <= 1'b1;
			s_q.rd_prev <= 1'b1;
			s_q.status <= `HPB_RST_STATUS;
			s_q.timeout <= `HPB_RST_TIMEOUT;
			s_q.data <= `HPB_RST_DATA;
			s_q.ownaddr <= `HPB_RST_OWNADDR;
			s_q.control <= `HPB_RST_CONTROL;
			s_q.st <= hpb_pkg::HPB_SER_IDLE;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ---- pkg/hpb_cfg.svh ----
// Constants of the parallel host port bridge
`ifndef HPB_CFG_SVH
`define HPB_CFG_SVH
`define HPB_DATA_W 8
`define HPB_SEL_W 2
`define HPB_SEL_STATUS 2'h0
`define HPB_SEL_DATA 2'h1
`define HPB_SEL_OWNADDR 2'h2
`define HPB_SEL_CONTROL 2'h3
`define HPB_RST_STATUS 8'hF8
`define HPB_RST_TIMEOUT 8'hFF
`define HPB_RST_DATA 8'h00
`define HPB_RST_OWNADDR 8'h00
`define HPB_RST_CONTROL 8'h00
`define HPB_STROBE_CYC 4
`define HPB_SETUP_CYC 2
`define HPB_CTL_ENABLE_BIT 6
`define HPB_CTL_IRQ_BIT 3
`define HPB_STA_IDLE 8'hF8
`define HPB_STA_BYTE_DONE 8'h28
`define HPB_BYTE_CYC 16
`endif

// ---- pkg/hpb_pkg.sv ----
// Types of the parallel host port bridge
package hpb_pkg;
	typedef logic [7:0] hpb_byte_type;
	typedef logic [1:0] hpb_sel_type;
	typedef enum logic [3:0] {
		HPB_SER_IDLE = 4'h1,
		HPB_SER_SHIFT = 4'h2,
		HPB_SER_DONE = 4'h4,
		HPB_SER_WAIT = 4'h8
	} hpb_ser_state_type;
	typedef enum logic [4:0] {
		HPB_HOST_IDLE = 5'h01,
		HPB_HOST_SETUP = 5'h02,
		HPB_HOST_STROBE = 5'h04,
		HPB_HOST_RELEASE = 5'h08,
		HPB_HOST_HOLD = 5'h10
	} hpb_host_state_type;
endpackage

// ---- pkg/hpb_if.sv ----
// Parallel host port pins shared by host and device
`timescale 1ns/1ps
interface hpb_if;
	logic chip_select_n;
	logic write_strobe_n;
	logic read_strobe_n;
	logic register_select_lsb;
	logic register_select_msb;
	logic [7:0] host_data_to_dev;
	logic [7:0] host_data_from_dev;
	logic dev_data_oe;
	logic host_data_oe;
	logic irq_drive_low;
	logic irq_n;
	logic [7:0] host_data_bus;
	assign host_data_bus = dev_data_oe ? host_data_from_dev : host_data_oe ? host_data_to_dev : 8'hFF;
	assign irq_n = irq_drive_low ? 1'b0 : 1'b1;
	modport device (
		input chip_select_n,
		input write_strobe_n,
		input read_strobe_n,
		input register_select_lsb,
		input register_select_msb,
		input host_data_bus,
		output host_data_from_dev,
		output dev_data_oe,
		output irq_drive_low
	);
	modport host (
		output chip_select_n,
		output write_strobe_n,
		output read_strobe_n,
		output register_select_lsb,
		output register_select_msb,
		output host_data_to_dev,
		output host_data_oe,
		input host_data_bus,
		input irq_n
	);
endinterface

// ---- rtl/hpb_host.sv ----
// Host end: drives strobes to read or write one device register per request
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module hpb_host #(
	parameter int STROBE_CYC = `HPB_STROBE_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	hpb_if.host bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_sel,
	input wire logic [7:0] req_wdata,
	output logic [7:0] rsp_rdata,
	output logic rsp_valid,
	output logic irq_pending
);
	initial begin
		if (STROBE_CYC < 4 || STROBE_CYC > 255) $error("STROBE_CYC out of range");
		if (`HPB_SETUP_CYC < 2) $error("HPB_SETUP_CYC too small for read capture");
	end
	typedef struct packed {
		hpb_pkg::hpb_host_state_type st;
		logic write;
		logic [1:0] sel;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [7:0] cnt;
		logic rsp;
		logic [7:0] d_s1, d_s2;
		logic i_s1, i_s2;
	} hpb_host_state_local_type;
	hpb_host_state_local_type s_q, s_d;
	logic active;
	assign active = s_q.st != hpb_pkg::HPB_HOST_IDLE;
	assign req_ready = ~active;
	assign bus.chip_select_n = ~active;
	assign bus.register_select_lsb = s_q.sel[0];
	assign bus.register_select_msb = s_q.sel[1];
	assign bus.write_strobe_n = ~(s_q.write & s_q.st == hpb_pkg::HPB_HOST_STROBE);
	assign bus.read_strobe_n = ~(~s_q.write & s_q.st == hpb_pkg::HPB_HOST_STROBE);
	assign bus.host_data_to_dev = s_q.wdata;
	assign bus.host_data_oe = s_q.write & active;
	assign rsp_rdata = s_q.rdata;
	assign rsp_valid = s_q.rsp;
	assign irq_pending = ~s_q.i_s2;
	always_comb begin
		s_d = s_q;
		s_d.rsp = 1'b0;
		s_d.d_s1 = bus.host_data_bus;
		s_d.d_s2 = s_q.d_s1;
		s_d.i_s1 = bus.irq_n;
		s_d.i_s2 = s_q.i_s1;
		s_d.cnt = s_q.cnt + 8'h01;
		case (s_q.st)
			hpb_pkg::HPB_HOST_IDLE: begin
				s_d.cnt = 8'h00;
				if (req_valid) begin
					s_d.write = req_write;
					s_d.sel = req_sel;
					s_d.wdata = req_wdata;
					s_d.st = hpb_pkg::HPB_HOST_SETUP;
				end
			end
			hpb_pkg::HPB_HOST_SETUP: if (s_q.cnt == 8'(`HPB_SETUP_CYC - 1)) begin
				s_d.cnt = 8'h00;
				s_d.st = hpb_pkg::HPB_HOST_STROBE;
			end
			hpb_pkg::HPB_HOST_STROBE: if (s_q.cnt == 8'(STROBE_CYC - 1)) begin
				s_d.cnt = 8'h00;
				s_d.st = hpb_pkg::HPB_HOST_RELEASE;
			end
			hpb_pkg::HPB_HOST_RELEASE: begin
				// Last driven read byte leaves the second flop two edges after the strobe rises
				if (s_q.cnt == 8'h01) s_d.rdata = s_q.d_s2;
				if (s_q.cnt == 8'(`HPB_SETUP_CYC - 1)) begin
					s_d.cnt = 8'h00;
					s_d.st = hpb_pkg::HPB_HOST_HOLD;
				end
			end
			hpb_pkg::HPB_HOST_HOLD: if (s_q.cnt == 8'(STROBE_CYC - 1)) begin
				s_d.rsp = 1'b1;
				s_d.st = hpb_pkg::HPB_HOST_IDLE;
			end
			default: s_d.st = hpb_pkg::HPB_HOST_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.st <= hpb_pkg::HPB_HOST_IDLE;
			s_q.i_s1 <= 1'b1;
			s_q.i_s2 <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ---- sim/hpb_checker.sv ----
// Concurrent checks on the host port pins between host and device
`timescale 1ns/1ps
module hpb_checker (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic register_select_lsb,
	input wire logic register_select_msb,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic irq_drive_low
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	a_cs_release: assert property (chip_select_n |-> !dev_data_oe)
		else $error("device drives data while deselected");
	a_rd_only_drive: assert property (dev_data_oe |-> !read_strobe_n)
		else $error("device drives data outside read strobe");
	a_no_clash: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	a_wr_needs_cs: assert property (!write_strobe_n |-> !chip_select_n)
		else $error("write strobe without chip select");
	a_rd_needs_cs: assert property (!read_strobe_n |-> !chip_select_n)
		else $error("read strobe without chip select");
	a_strobe_excl: assert property (!(!write_strobe_n && !read_strobe_n))
		else $error("read and write strobes low together");
	a_wr_len: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*4] ##1 write_strobe_n)
		else $error("write strobe length wrong");
	a_rd_len: assert property ($fell(read_strobe_n) |-> (!read_strobe_n)[*4] ##1 read_strobe_n)
		else $error("read strobe length wrong");
	a_sel_stable: assert property (!chip_select_n && $past(!chip_select_n)
		|-> $stable({register_select_msb, register_select_lsb}))
		else $error("register select moved during access");
	a_wdata_held: assert property (!write_strobe_n |-> host_data_oe)
		else $error("write data not driven during write strobe");
	a_rd_drive: assert property ($fell(read_strobe_n) |-> ##[0:3] dev_data_oe)
		else $error("device did not drive read data");
	a_reset_quiet: assert property ($past(!reset_n) |-> !irq_drive_low && !dev_data_oe)
		else $error("outputs not released after reset");
endmodule

// ---- sim/tb.sv ----
// Testbench joining host and device ends through the host port interface
`timescale 1ns/1ps
`include "hpb_cfg.svh"
module tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic rx_ready = 1'b1;
	logic [1:0] req_sel = 2'h0;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] rd;
	logic req_ready, rsp_valid, irq_pending, ser_out, ser_clk, rx_valid;
	logic [7:0] rsp_rdata, rx_byte;
	logic [7:0] rst_tab [4] = '{`HPB_RST_STATUS, `HPB_RST_DATA, `HPB_RST_OWNADDR, `HPB_RST_CONTROL};
	logic [7:0] ser_edges = 8'h00;
	logic ser_clk_d = 1'b0;
	int err_count = 0;
	int checks = 0;
	int n;
	always #2 clk_sys = ~clk_sys;
	// Counts serial clock rising edges to see one byte per start
	always @(posedge clk_sys) begin
		ser_clk_d <= ser_clk;
		if (ser_clk === 1'b1 && ser_clk_d === 1'b0) ser_edges <= ser_edges + 8'h01;
	end
	hpb_if link();
	hpb_host hpb_host_i (.clk_sys(clk_sys), .reset_n(reset_n), .bus(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_sel(req_sel), .req_wdata(req_wdata),
		.rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .irq_pending(irq_pending));
	// Serial loopback so the received byte equals the sent one
	hpb_device #(.BYTE_CYC(2)) hpb_device_i (.clk_sys(clk_sys), .reset_n(reset_n), .bus(link),
		.ser_in(ser_out), .ser_out(ser_out), .ser_clk(ser_clk), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_ready(rx_ready));
	hpb_checker hpb_checker_i (.clk_sys(clk_sys), .reset_n(reset_n), .chip_select_n(link.chip_select_n),
		.write_strobe_n(link.write_strobe_n), .read_strobe_n(link.read_strobe_n),
		.register_select_lsb(link.register_select_lsb), .register_select_msb(link.register_select_msb),
		.host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe), .irq_drive_low(link.irq_drive_low));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic acc(input logic wr, input logic [1:0] sel, input logic [7:0] wd, output logic [7:0] q);
		int k;
		k = 0;
		q = 8'hXX;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= wr;
		req_sel <= sel;
		req_wdata <= wd;
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && k < 40) begin
			@(negedge clk_sys);
			k++;
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		k = 0;
		while (k < 40) begin
			@(negedge clk_sys);
			if (rsp_valid === 1'b1) begin
				q = rsp_rdata;
				break;
			end
			k++;
		end
		if (k >= 40) chk("access response", 8'h01, 8'h00);
	endtask
	task automatic do_reset();
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		$display("Error watchdog expected finish seen timeout");
		wrap_up();
	end
	initial begin
		do_reset();
		for (int s = 0; s < 4; s++) begin
			acc(1'b0, s[1:0], 8'h00, rd);
			chk("reset value", rst_tab[s], rd);
		end
		$display("test reset values done");
		acc(1'b1, `HPB_SEL_OWNADDR, 8'hA5, rd);
		acc(1'b0, `HPB_SEL_OWNADDR, 8'h00, rd);
		chk("own address", 8'hA5, rd);
		acc(1'b1, `HPB_SEL_STATUS, 8'h12, rd);
		acc(1'b0, `HPB_SEL_STATUS, 8'h00, rd);
		chk("status after timeout write", `HPB_RST_STATUS, rd);
		acc(1'b1, `HPB_SEL_DATA, 8'h5A, rd);
		acc(1'b0, `HPB_SEL_DATA, 8'h00, rd);
		chk("data", 8'h5A, rd);
		$display("test write read done");
		@(posedge clk_sys);
		rx_ready <= 1'b0;
		acc(1'b1, `HPB_SEL_CONTROL, 8'h40, rd);
		n = 0;
		while (irq_pending !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk("irq pending", 8'h01, {7'h00, irq_pending});
		chk("serial clock edges", 8'h08, ser_edges);
		acc(1'b0, `HPB_SEL_STATUS, 8'h00, rd);
		chk("status byte done", `HPB_STA_BYTE_DONE, rd);
		chk("rx valid", 8'h01, {7'h00, rx_valid});
		chk("rx byte", 8'h5A, rx_byte);
		acc(1'b1, `HPB_SEL_CONTROL, 8'h00, rd);
		repeat (6) @(negedge clk_sys);
		chk("irq cleared", 8'h00, {7'h00, irq_pending});
		acc(1'b0, `HPB_SEL_STATUS, 8'h00, rd);
		chk("status idle", `HPB_STA_IDLE, rd);
		@(posedge clk_sys);
		rx_ready <= 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("rx drained", 8'h00, {7'h00, rx_valid});
		$display("test byte exchange done");
		acc(1'b1, `HPB_SEL_OWNADDR, 8'h77, rd);
		do_reset();
		acc(1'b0, `HPB_SEL_OWNADDR, 8'h00, rd);
		chk("own address after reset", `HPB_RST_OWNADDR, rd);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule
